//--- hdl/ccdw_pkg.sv
// Purpose: constants shared by the charge current setpoint and watchdog block
// Assumes: 40 MHz pclk, APB register access, 32-bit data
// Notes: times are kept in their own units; cycle counts are derived here
package ccdw_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned WDOG_TIME_MS = 1000;
    localparam int unsigned SLOW_STEP_TIME_MS = 40;
    // least times, exact at this rate
    localparam int unsigned WDOG_CYCLES = (CLK_HZ / 1000) * WDOG_TIME_MS;
    localparam int unsigned SLOW_STEP_CYCLES = (CLK_HZ / 1000) * SLOW_STEP_TIME_MS;

    localparam int CODE_W = 10;
    localparam logic [CODE_W-1:0] CODE_FULL_SCALE = 10'h3ff;
    localparam int PWM_W = 3;
    localparam logic [PWM_W-1:0] PWM_ON_COUNT = 3'h0;

    // register byte addresses
    localparam logic [7:0] ADDR_SETPOINT = 8'h00;
    localparam logic [7:0] ADDR_CHARGER = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // setpoint fields
    localparam int SP_CODE_LSB = 0;
    localparam int SP_LOW_BIT = 10;
    // charger fields
    localparam int CH_FIRST_BIT = 0;
    localparam int CH_SECOND_BIT = 1;
    // status fields
    localparam int ST_FIRST_BIT = 0;
    localparam int ST_SECOND_BIT = 1;
    localparam int ST_FEEDBACK_BIT = 2;
    localparam int ST_RUN_BIT = 3;
    localparam int ST_DAC_BIT = 4;
    localparam int ST_EXPIRED_BIT = 5;

    localparam logic [CODE_W-1:0] SP_CODE_RESET = 10'h000;

    typedef enum logic [1:0] {
        CCDW_CHG_IDLE = 2'b00,
        CCDW_CHG_RUN = 2'b01
    } ccdw_chg_e;
endpackage

//--- hdl/ccdw_dsm.sv
// Purpose: first-order delta-sigma modulator for the current setpoint
// Assumes: step is a one-cycle enable
// Notes: residue kept in 0..1022 so ones density is exactly code/1023
`timescale 1ns/10ps
`default_nettype none
module ccdw_dsm (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic step,
    input wire logic [ccdw_pkg::CODE_W-1:0] code,
    // modulated bit
    output logic bit_out
);
    import ccdw_pkg::*;

    logic [CODE_W-1:0] acc_reg;
    logic [CODE_W-1:0] acc_next;
    logic bit_reg;
    logic bit_next;
    logic [CODE_W:0] sum;

    always_comb begin
        sum = {1'b0, acc_reg} + {1'b0, code};
        acc_next = acc_reg;
        bit_next = bit_reg;
        if (step) begin
            if (sum >= {1'b0, CODE_FULL_SCALE}) begin
                acc_next = CODE_W'(sum - {1'b0, CODE_FULL_SCALE});
                bit_next = 1'b1;
            end else begin
                acc_next = sum[CODE_W-1:0];
                bit_next = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= '0;
            bit_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            bit_reg <= bit_next;
        end
    end

    assign bit_out = bit_reg;
endmodule
`default_nettype wire

//--- hdl/ccdw_top.sv
// Purpose: charge current setpoint modulator, pack enables and charger watchdog
// Assumes: APB slave with no wait cycles; comparator inputs synchronous to pclk
// Notes: long counts are parameters so simulation can shorten them
`timescale 1ns/10ps
`default_nettype none
module ccdw_top #(
    parameter int unsigned WDOG_COUNT = ccdw_pkg::WDOG_CYCLES,
    parameter int unsigned SLOW_STEP_COUNT = ccdw_pkg::SLOW_STEP_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pack voltage comparators, high when above min_charge_voltage
    input wire logic first_pack_above_min,
    input wire logic second_pack_above_min,
    // charger controls
    output logic current_dac_switch,
    output logic charge_first_pack,
    output logic charge_second_pack,
    output logic feedback_from_second,
    output logic charger_run
);
    import ccdw_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register decode

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
        addr_hit = (a == off);
    endfunction

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = addr_hit(a, ADDR_SETPOINT) | addr_hit(a, ADDR_CHARGER)
            | addr_hit(a, ADDR_STATUS);
    endfunction

    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [CODE_W-1:0] code_reg, code_next;
    logic low_reg, low_next;
    logic en_first_reg, en_first_next;
    logic en_second_reg, en_second_next;
    logic expired_reg, expired_next;
    ccdw_chg_e chg_reg, chg_next;
    logic [25:0] wdog_reg, wdog_next;
    logic [20:0] slow_reg, slow_next;
    logic [PWM_W-1:0] pwm_reg, pwm_next;
    logic dac_reg, dac_next;
    logic first_reg, first_next;
    logic second_reg, second_next;
    logic fb_reg, fb_next;
    logic run_reg, run_next;

    logic access_done;
    logic wr_setpoint;
    logic wr_charger;
    logic slow_tick;
    logic dsm_step;
    logic ds_bit;
    logic both_en;
    logic [31:0] status_word;

    ////////////////////////////////////////////////////////////////////////
    // apb slave

    assign access_done = psel & penable & pready_reg;
    assign wr_setpoint = access_done & pwrite & addr_hit(paddr, ADDR_SETPOINT);
    assign wr_charger = access_done & pwrite & addr_hit(paddr, ADDR_CHARGER);

    always_comb begin
        status_word = '0;
        status_word[ST_FIRST_BIT] = first_reg;
        status_word[ST_SECOND_BIT] = second_reg;
        status_word[ST_FEEDBACK_BIT] = fb_reg;
        status_word[ST_RUN_BIT] = run_reg;
        status_word[ST_DAC_BIT] = dac_reg;
        status_word[ST_EXPIRED_BIT] = expired_reg;
    end

    always_comb begin
        // no wait cycle: answer is prepared during the setup phase
        pready_next = psel & ~penable;
        pslverr_next = 1'b0;
        prdata_next = prdata_reg;
        if (psel & ~penable) begin
            pslverr_next = ~addr_mapped(paddr);
            prdata_next = '0;
            if (!pwrite) begin
                unique case (1'b1)
                    addr_hit(paddr, ADDR_SETPOINT): begin
                        prdata_next[SP_CODE_LSB +: CODE_W] = code_reg;
                        prdata_next[SP_LOW_BIT] = low_reg;
                    end
                    addr_hit(paddr, ADDR_CHARGER): begin
                        prdata_next[CH_FIRST_BIT] = en_first_reg;
                        prdata_next[CH_SECOND_BIT] = en_second_reg;
                    end
                    addr_hit(paddr, ADDR_STATUS): prdata_next = status_word;
                    default: prdata_next = '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // setpoint, charger enables and watchdog

    always_comb begin
        code_next = code_reg;
        low_next = low_reg;
        if (wr_setpoint) begin
            code_next = pwdata[SP_CODE_LSB +: CODE_W];
            low_next = pwdata[SP_LOW_BIT];
        end
    end

    always_comb begin
        en_first_next = en_first_reg;
        en_second_next = en_second_reg;
        wdog_next = wdog_reg;
        expired_next = expired_reg;
        chg_next = chg_reg;
        unique case (chg_reg)
            CCDW_CHG_IDLE: begin
                if (wr_charger) begin
                    en_first_next = pwdata[CH_FIRST_BIT];
                    en_second_next = pwdata[CH_SECOND_BIT];
                    wdog_next = '0;
                    expired_next = 1'b0;
                    if (pwdata[CH_FIRST_BIT] | pwdata[CH_SECOND_BIT]) begin
                        chg_next = CCDW_CHG_RUN;
                    end
                end
            end
            CCDW_CHG_RUN: begin
                if (wr_charger) begin
                    // any write restarts the interval, even with the same data
                    en_first_next = pwdata[CH_FIRST_BIT];
                    en_second_next = pwdata[CH_SECOND_BIT];
                    wdog_next = '0;
                    if (!(pwdata[CH_FIRST_BIT] | pwdata[CH_SECOND_BIT])) begin
                        chg_next = CCDW_CHG_IDLE;
                    end
                end else if (wdog_reg == 26'(WDOG_COUNT - 1)) begin
                    en_first_next = 1'b0;
                    en_second_next = 1'b0;
                    expired_next = 1'b1;
                    chg_next = CCDW_CHG_IDLE;
                end else begin
                    wdog_next = wdog_reg + 26'h1;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // pack selection

    assign both_en = en_first_reg & en_second_reg;

    always_comb begin
        run_next = (chg_reg == CCDW_CHG_RUN);
        first_next = 1'b0;
        second_next = 1'b0;
        if (chg_reg == CCDW_CHG_RUN) begin
            if (low_reg) begin
                // no voltage qualification; second pack only if it is alone
                first_next = en_first_reg;
                second_next = en_second_reg & ~en_first_reg;
            end else if (both_en) begin
                first_next = first_pack_above_min;
                second_next = second_pack_above_min;
            end else begin
                first_next = en_first_reg;
                second_next = en_second_reg;
            end
        end
        fb_next = first_next & second_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // modulator timing and output

    // slow step pulse; restarts on a setpoint write so the first slow bit
    // is a full period long
    assign slow_tick = (slow_reg == 21'(SLOW_STEP_COUNT - 1));
    assign dsm_step = low_reg ? slow_tick : 1'b1;

    always_comb begin
        slow_next = slow_reg + 21'h1;
        if (slow_tick | ~low_reg | wr_setpoint) begin
            slow_next = '0;
        end
        pwm_next = pwm_reg + 3'h1;
        if (low_reg) begin
            dac_next = ds_bit & (pwm_reg == PWM_ON_COUNT);
        end else begin
            dac_next = ds_bit;
        end
    end

    ccdw_dsm u_dsm (
        .pclk(pclk),
        .presetn(presetn),
        .step(dsm_step),
        .code(code_reg),
        .bit_out(ds_bit)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            code_reg <= SP_CODE_RESET;
            low_reg <= 1'b0;
            en_first_reg <= 1'b0;
            en_second_reg <= 1'b0;
            expired_reg <= 1'b0;
            chg_reg <= CCDW_CHG_IDLE;
            wdog_reg <= '0;
            slow_reg <= '0;
            pwm_reg <= '0;
            dac_reg <= 1'b0;
            first_reg <= 1'b0;
            second_reg <= 1'b0;
            fb_reg <= 1'b0;
            run_reg <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            code_reg <= code_next;
            low_reg <= low_next;
            en_first_reg <= en_first_next;
            en_second_reg <= en_second_next;
            expired_reg <= expired_next;
            chg_reg <= chg_next;
            wdog_reg <= wdog_next;
            slow_reg <= slow_next;
            pwm_reg <= pwm_next;
            dac_reg <= dac_next;
            first_reg <= first_next;
            second_reg <= second_next;
            fb_reg <= fb_next;
            run_reg <= run_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign current_dac_switch = dac_reg;
    assign charge_first_pack = first_reg;
    assign charge_second_pack = second_reg;
    assign feedback_from_second = fb_reg;
    assign charger_run = run_reg;
endmodule
`default_nettype wire

//--- testbench/ccdw_top_chk.sv
// Purpose: port checker for ccdw_top
// Assumes: master keeps the apb handshake
// Notes: watchdog bound tracked by a helper counter
`timescale 1ns/10ps
`default_nettype none
module ccdw_top_chk #(
    parameter int unsigned WDOG_COUNT = 200,
    parameter int unsigned SLOW_STEP_COUNT = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // charger
    input wire logic charge_first_pack,
    input wire logic charge_second_pack,
    input wire logic feedback_from_second,
    input wire logic charger_run
);
    import ccdw_pkg::*;
    logic [31:0] wcnt_reg;
    logic [31:0] wcnt_next;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_chg_wr;
        psel && penable && pready && pwrite && paddr == ADDR_CHARGER;
    endsequence
    ////////////////////////////////////////////////////////////////////
    // cycles since the last charger write, saturating
    always_comb begin
        wcnt_next = wcnt_reg;
        if (psel && penable && pready && pwrite && paddr == ADDR_CHARGER) begin
            wcnt_next = 32'h0;
        end else if (wcnt_reg != 32'hffff_ffff) begin
            wcnt_next = wcnt_reg + 32'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wcnt_reg <= 32'h0;
        end else begin
            wcnt_reg <= wcnt_next;
        end
    end
    ////////////////////////////////////////////////////////////////////
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("pready stood two cycles");
    AST_READY_NEXT: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_START: assert property (s_chg_wr ##0 (pwdata[1:0] != 2'h0) |-> ##2 charger_run)
        else $error("charger did not start");
    AST_STOP: assert property (s_chg_wr ##0 (pwdata[1:0] == 2'h0) |-> ##2 !charger_run)
        else $error("charger did not stop");
    AST_EXPIRE: assert property (wcnt_reg > WDOG_COUNT + 1 |-> !charger_run)
        else $error("charger ran past watchdog");
    AST_IDLE: assert property (!charger_run |-> !charge_first_pack && !charge_second_pack)
        else $error("pack charging while idle");
    AST_FEEDBACK: assert property (feedback_from_second == (charge_first_pack && charge_second_pack))
        else $error("feedback source wrong");
endmodule
bind ccdw_top ccdw_top_chk #(.WDOG_COUNT(WDOG_COUNT), .SLOW_STEP_COUNT(SLOW_STEP_COUNT))
    i_ccdw_top_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .charge_first_pack(charge_first_pack), .charge_second_pack(charge_second_pack),
    .feedback_from_second(feedback_from_second), .charger_run(charger_run));
`default_nettype wire

//--- testbench/ccdw_pack_model.sv
// Purpose: pack voltage comparators seen by the block
// Assumes: voltages in millivolts, set by the bench
// Notes: threshold value is a plain default
`timescale 1ns/10ps
`default_nettype none
module ccdw_pack_model #(
    parameter logic [15:0] MIN_MV = 16'h1388
) (
    // pack voltages
    input wire logic [15:0] first_mv,
    input wire logic [15:0] second_mv,
    // comparator levels
    output logic first_above,
    output logic second_above
);
    assign first_above = first_mv > MIN_MV;
    assign second_above = second_mv > MIN_MV;
endmodule
`default_nettype wire

//--- testbench/ccdw_tb_top.sv
// Purpose: self-checking bench for ccdw_top
// Assumes: watchdog shortened to 2000 cycles, slow step to 16
// Notes: bus answers taken at the rising edge, other outputs at the falling edge
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module ccdw_tb_top;
    import ccdw_pkg::*;
    localparam int unsigned WD = 2000;
    localparam int unsigned SL = 16;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, d;
    logic pready, pslverr, err, dac, c1, c2, fb, run, a1, a2;
    logic [15:0] mv1 = 16'h0, mv2 = 16'h0;
    int error_cnt = 0, total_checks = 0, seed = 70344;
    // unknown output bits must not pass as zero
    logic [31:0] ones;
    int codes[4] = '{0, 1023, 1, 700};
    always #12.5 pclk = ~pclk;
    ccdw_top #(.WDOG_COUNT(WD), .SLOW_STEP_COUNT(SL)) i_ccdw_top (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .first_pack_above_min(a1), .second_pack_above_min(a2), .current_dac_switch(dac),
        .charge_first_pack(c1), .charge_second_pack(c2), .feedback_from_second(fb),
        .charger_run(run));
    ccdw_pack_model i_ccdw_pack_model (.first_mv(mv1), .second_mv(mv2), .first_above(a1),
        .second_above(a2));
    ////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one apb transfer; ends one rising edge after the edge where pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    function automatic logic [2:0] exp_sel(input logic lo, input logic [1:0] en,
                                           input logic [1:0] ab);
        logic f, s;
        if (lo) begin
            f = en[0];
            s = en[1] & ~en[0];
        end else if (&en) begin
            f = ab[0];
            s = ab[1];
        end else begin
            f = en[0];
            s = en[1];
        end
        return {f & s, s, f};
    endfunction
    ////////////////////////////////////////////////////////////////////
    initial begin
        #750000;
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_SETPOINT, 32'h0); `CHK(rd, 32'h0)
        apb(1'b0, ADDR_STATUS, 32'h0); `CHK(rd, 32'h0)
        apb(1'b1, 8'h0c, 32'hffff_ffff); `CHK(err, 1'b1)
        apb(1'b0, 8'h0c, 32'h0); `CHK({err, rd}, {1'b1, 32'h0})
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            apb(1'b1, ADDR_SETPOINT, d);
            apb(1'b0, ADDR_SETPOINT, 32'h0); `CHK(rd, d & 32'h7ff)
        end
        $display("test registers done");
        codes[3] = $random(seed) & 32'h3ff;
        foreach (codes[i]) begin
            apb(1'b1, ADDR_CHARGER, 32'h1);
            apb(1'b1, ADDR_SETPOINT, 32'(codes[i]));
            // two register stages: the first bit after return is still the old code
            @(posedge pclk);
            ones = 32'h0;
            repeat (1023) begin
                @(negedge pclk);
                ones = ones + 32'(dac);
            end
            `CHK(ones, codes[i])
            @(posedge pclk);
        end
        // low mode: full code gives one pulse in eight, zero code none
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, ADDR_CHARGER, 32'h1);
            apb(1'b1, ADDR_SETPOINT, k ? 32'h400 : 32'h7ff);
            // old bit must survive until the first slow step: two chop pulses
            ones = 32'h0;
            repeat (SL) begin
                @(negedge pclk);
                ones = ones + 32'(dac);
            end
            if (k == 1) `CHK(ones, 32'h2)
            @(posedge pclk);
            ones = 32'h0;
            repeat (64) begin
                @(negedge pclk);
                ones = ones + 32'(dac);
            end
            `CHK(ones, k ? 0 : 8)
            @(posedge pclk);
        end
        $display("test modulator done");
        for (int m = 1; m >= 0; m--) begin // low mode first, as for a depleted pack
            apb(1'b1, ADDR_SETPOINT, {21'h0, m[0], 10'h155});
            for (int e = 1; e < 4; e++) begin
                for (int c = 0; c < 4; c++) begin
                    mv1 <= c[0] ? 16'h1389 + 16'($random(seed) & 16'h3ff) : 16'h0bb8;
                    mv2 <= c[1] ? 16'h1770 : 16'($random(seed) & 16'h0fff);
                    apb(1'b1, ADDR_CHARGER, 32'(e));
                    look(2);
                    `CHK({fb, c2, c1}, exp_sel(m[0], 2'(e), 2'(c)))
                    @(posedge pclk);
                end
            end
        end
        $display("test selection done");
        apb(1'b1, ADDR_CHARGER, 32'h1); // one pack first
        repeat (WD - 10) @(posedge pclk);
        apb(1'b1, ADDR_CHARGER, 32'h3); // then both, charger kept running
        look(WD - 10);
        `CHK(run, 1'b1)
        look(20);
        `CHK({run, c2, c1}, 3'h0)
        @(posedge pclk);
        apb(1'b0, ADDR_CHARGER, 32'h0); `CHK(rd[1:0], 2'h0)
        apb(1'b0, ADDR_STATUS, 32'h0); `CHK(rd[5], 1'b1)
        apb(1'b1, ADDR_CHARGER, 32'h2);
        apb(1'b0, ADDR_STATUS, 32'h0); `CHK({rd[5], rd[3:0]}, 5'h0a)
        apb(1'b1, ADDR_CHARGER, 32'h0);
        look(1);
        `CHK(run, 1'b0)
        $display("test watchdog done");
        stop_test();
    end
endmodule
`default_nettype wire
